/* rtl/alcs_regs.svh */
// register offsets, field positions, reset values and sizes of the control slave
`ifndef ALCS_REGS_SVH
`define ALCS_REGS_SVH

// ****************************************
// byte offsets
// ****************************************
`define ALCS_OFF_CTRL      12'h000
`define ALCS_OFF_GIE       12'h004
`define ALCS_OFF_IER       12'h008
`define ALCS_OFF_ISR       12'h00C
`define ALCS_OFF_A         12'h010
`define ALCS_OFF_B_DATA    12'h018
`define ALCS_OFF_B_VLD     12'h01C
`define ALCS_OFF_B_ACK     12'h020
`define ALCS_OFF_C_DATA    12'h400
`define ALCS_OFF_C_VLD     12'h404
`define ALCS_OFF_MEM_BASE  12'h800

// ****************************************
// field positions
// ****************************************
`define ALCS_CTRL_START    0
`define ALCS_CTRL_DONE     1
`define ALCS_CTRL_IDLE     2
`define ALCS_CTRL_READY    3
`define ALCS_CTRL_AUTO     7
`define ALCS_ISR_DONE      0
`define ALCS_ISR_READY     1

// ****************************************
// reset values and sizes
// ****************************************
`define ALCS_ARG_RESET     32'h0000_0000
`define ALCS_MEM_AW        4
`define ALCS_MEM_WORDS     16

`endif

/* rtl/alcs_pkg.sv */
// types shared by the control slave and the synthesized core
package alcs_pkg;

    // ****************************************
    // core-facing signal groups
    // ****************************************
    typedef struct packed {
        logic        done;     // completion_flag pulse
        logic        idle;     // core idle level
        logic        ready;    // input_ready_flag pulse
        logic        b_ack;    // core consumed argument b
        logic        c_vld;    // core wrote argument c
        logic [31:0] c_data;   // result c
    } alcs_core_in_t;

    typedef struct packed {
        logic        start;    // run request
        logic        b_vld;    // argument b qualified
        logic [31:0] a_data;   // argument a
        logic [31:0] b_data;   // argument b
    } alcs_core_out_t;

endpackage

/* rtl/alcs_mem.sv */
// packed argument array: bus write port, two registered read ports
`timescale 1ns/1ps
`include "alcs_regs.svh"

module alcs_mem (
    // clock
    input  wire logic                      sys_clk,
    // bus side
    input  wire logic                      wr_en,
    input  wire logic [`ALCS_MEM_AW-1:0]   wr_addr,
    input  wire logic [31:0]               wr_data,
    input  wire logic [`ALCS_MEM_AW-1:0]   bus_addr,
    output logic      [31:0]               bus_rdata,
    // core side
    input  wire logic [`ALCS_MEM_AW-1:0]   core_addr,
    output logic      [31:0]               core_rdata
);

    logic [31:0] mem_q [`ALCS_MEM_WORDS];  // storage, four bytes per word

    // ****************************************
    // write and registered reads
    // ****************************************
    always_ff @(posedge sys_clk) begin
        if (wr_en) begin
            mem_q[wr_addr] <= wr_data;
        end
        bus_rdata  <= mem_q[bus_addr];
        core_rdata <= mem_q[core_addr];
    end

endmodule

/* rtl/alcs_slave.sv */
// control slave: block control, interrupt, handshaked arguments and array over apb
//
// Design decisions made here: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "alcs_regs.svh"

module alcs_slave #(
    parameter bit REG_RESET = 1'b1          // build-time: reset argument registers
) (
    // clock and reset
    input  wire logic                   sys_clk,
    input  wire logic                   rst_n,
    // apb slave
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [11:0]            paddr,
    input  wire logic [31:0]            pwdata,
    output logic      [31:0]            prdata,
    output logic                        pready,
    output logic                        pslverr,
    // synthesized core
    input  wire alcs_pkg::alcs_core_in_t  core_in,
    output alcs_pkg::alcs_core_out_t      core_out,
    input  wire logic [`ALCS_MEM_AW-1:0] core_mem_addr,
    output logic      [31:0]            core_mem_rdata,
    // interrupt
    output logic                        irq
);

    // ****************************************
    // address decode
    // ****************************************
    // word match on an aligned offset, used by both read and write decode
    function automatic logic hit(input logic [11:0] addr, input logic [11:0] off);
        hit = (addr[11:2] == off[11:2]);
    endfunction

    wire logic access    = psel & penable & ~pready;      // first access cycle
    wire logic done_xfer = psel & penable & pready;       // completion edge
    wire logic wr_fire   = done_xfer & pwrite;            // write takes effect
    wire logic rd_fire   = done_xfer & ~pwrite;           // read taken

    // register map: control words low, arguments above, c at explicit offset
    wire logic sel_ctrl  = hit(paddr, `ALCS_OFF_CTRL);
    wire logic sel_gie   = hit(paddr, `ALCS_OFF_GIE);
    wire logic sel_ier   = hit(paddr, `ALCS_OFF_IER);
    wire logic sel_isr   = hit(paddr, `ALCS_OFF_ISR);
    wire logic sel_a     = hit(paddr, `ALCS_OFF_A);
    wire logic sel_bdat  = hit(paddr, `ALCS_OFF_B_DATA);
    wire logic sel_bvld  = hit(paddr, `ALCS_OFF_B_VLD);
    wire logic sel_back  = hit(paddr, `ALCS_OFF_B_ACK);
    wire logic sel_cdat  = hit(paddr, `ALCS_OFF_C_DATA);
    wire logic sel_cvld  = hit(paddr, `ALCS_OFF_C_VLD);
    wire logic sel_mem   = (paddr[11:6] == 6'(`ALCS_OFF_MEM_BASE >> 6));   // array words
    wire logic mapped    = sel_ctrl | sel_gie | sel_ier | sel_isr | sel_a | sel_bdat
                         | sel_bvld | sel_back | sel_cdat | sel_cvld | sel_mem;

    // ****************************************
    // state registers
    // ****************************************
    logic        start_reg,  start_next;   // run request
    logic        auto_reg;                 // auto-restart enable
    logic        done_reg,   done_next;    // sticky completion, clear on read
    logic        idle_reg;                 // sampled core idle
    logic        ready_reg;                // sampled input ready
    logic        gie_reg;                  // global interrupt enable
    logic [1:0]  ier_reg;                  // per-event enable
    logic [1:0]  isr_reg,    isr_next;     // sticky event status
    logic [31:0] a_reg;                    // argument a
    logic [31:0] b_reg;                    // argument b data
    logic        bvld_reg,   bvld_next;    // argument b valid
    logic        back_reg,   back_next;    // argument b read acknowledge
    logic [31:0] c_reg;                    // result c
    logic        cvld_reg,   cvld_next;    // result c valid
    logic [31:0] mem_bus_rdata;            // array read for the bus

    // ****************************************
    // next-state logic
    // ****************************************
    wire logic [1:0] ev_set  = {core_in.ready, core_in.done};
    wire logic [1:0] isr_clr = (wr_fire & sel_isr) ? pwdata[1:0] : 2'h0;            // write one clears

    // start drops when core takes inputs, unless auto-restart keeps it up
    assign start_next = (wr_fire & sel_ctrl & pwdata[`ALCS_CTRL_START])
                      | (start_reg & ~(core_in.ready & ~auto_reg));
    // set wins over clear-on-read
    assign done_next  = core_in.done | (done_reg & ~(rd_fire & sel_ctrl));
    assign isr_next   = ev_set | (isr_reg & ~isr_clr);
    // master write sets valid, core consumption clears it, set wins
    assign bvld_next  = (wr_fire & sel_bvld & pwdata[0]) | (bvld_reg & ~core_in.b_ack);
    // acknowledge sticks until software reads it
    assign back_next  = core_in.b_ack | (back_reg & ~(rd_fire & sel_back));
    assign cvld_next  = core_in.c_vld | (cvld_reg & ~(rd_fire & sel_cvld));

    // ****************************************
    // read multiplexer
    // ****************************************
    wire logic [31:0] ctrl_word = {24'h00_0000, auto_reg, 3'h0, ready_reg, idle_reg, done_reg, start_reg};
    wire logic [31:0] rd_word =
        sel_ctrl ? ctrl_word :
        sel_gie  ? {31'h0000_0000, gie_reg} :
        sel_ier  ? {30'h0000_0000, ier_reg} :
        sel_isr  ? {30'h0000_0000, isr_reg} :
        sel_a    ? a_reg :
        sel_bdat ? b_reg :
        sel_bvld ? {31'h0000_0000, bvld_reg} :
        sel_back ? {31'h0000_0000, back_reg} :
        sel_cdat ? c_reg :
        sel_cvld ? {31'h0000_0000, cvld_reg} :
        sel_mem  ? mem_bus_rdata : 32'h0000_0000;

    // ****************************************
    // apb answer: pready in the second access cycle
    // ****************************************
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= access;
            pslverr <= access & ~mapped;                         // unmapped gets slverr
            prdata  <= (access & ~pwrite) ? rd_word : 32'h0000_0000;
        end
    end

    // ****************************************
    // block control and interrupt
    // ****************************************
    // registers share the core clock
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            start_reg <= 1'b0;
            auto_reg  <= 1'b0;
            done_reg  <= 1'b0;
            idle_reg  <= 1'b1;
            ready_reg <= 1'b0;
            gie_reg   <= 1'b0;
            ier_reg   <= 2'h0;
            isr_reg   <= 2'h0;
            irq       <= 1'b0;
        end else begin
            start_reg <= start_next;
            done_reg  <= done_next;
            idle_reg  <= core_in.idle;
            ready_reg <= core_in.ready;
            isr_reg   <= isr_next;
            irq       <= gie_reg & |(isr_reg & ier_reg);
            if (wr_fire & sel_ctrl) begin
                auto_reg <= pwdata[`ALCS_CTRL_AUTO];
            end
            if (wr_fire & sel_gie) begin
                gie_reg <= pwdata[0];
            end
            if (wr_fire & sel_ier) begin
                ier_reg <= pwdata[1:0];
            end
        end
    end

    // ****************************************
    // handshake flags, always reset
    // ****************************************
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            bvld_reg <= 1'b0;
            back_reg <= 1'b0;
            cvld_reg <= 1'b0;
        end else begin
            bvld_reg <= bvld_next;
            back_reg <= back_next;
            cvld_reg <= cvld_next;
        end
    end

    // ****************************************
    // argument data, reset only if built so
    // ****************************************
    always_ff @(posedge sys_clk) begin
        if (REG_RESET && !rst_n) begin
            a_reg <= `ALCS_ARG_RESET;
            b_reg <= `ALCS_ARG_RESET;
            c_reg <= `ALCS_ARG_RESET;
        end else begin
            if (wr_fire & sel_a) begin
                a_reg <= pwdata;
            end
            if (wr_fire & sel_bdat) begin
                b_reg <= pwdata;
            end
            if (core_in.c_vld) begin
                c_reg <= core_in.c_data;
            end
        end
    end

    // ****************************************
    // core outputs from flops
    // ****************************************
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            core_out <= '0;
        end else begin
            core_out.start  <= start_next;
            core_out.b_vld  <= bvld_next;                        // core stalls while low
            core_out.a_data <= (wr_fire & sel_a) ? pwdata : a_reg;
            core_out.b_data <= (wr_fire & sel_bdat) ? pwdata : b_reg;
        end
    end

    // ****************************************
    // packed argument array
    // ****************************************
    alcs_mem u_mem (
        .sys_clk    (sys_clk),
        .wr_en      (wr_fire & sel_mem),
        .wr_addr    (paddr[`ALCS_MEM_AW+1:2]),
        .wr_data    (pwdata),
        .bus_addr   (paddr[`ALCS_MEM_AW+1:2]),
        .bus_rdata  (mem_bus_rdata),
        .core_addr  (core_mem_addr),
        .core_rdata (core_mem_rdata)
    );

endmodule

/* verification/alcs_slave_assertions.sv */
// port-level checks of the control slave
`timescale 1ns/1ps
`include "alcs_regs.svh"

module alcs_slave_assertions (
    // clock and reset
    input wire logic                     sys_clk,
    input wire logic                     rst_n,
    // apb slave
    input wire logic                     psel,
    input wire logic                     penable,
    input wire logic                     pwrite,
    input wire logic [11:0]              paddr,
    input wire logic [31:0]              pwdata,
    input wire logic [31:0]              prdata,
    input wire logic                     pready,
    input wire logic                     pslverr,
    // core side and interrupt
    input wire alcs_pkg::alcs_core_in_t  core_in,
    input wire alcs_pkg::alcs_core_out_t core_out,
    input wire logic                     irq
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // ****************************************
    // write completion decodes
    // ****************************************
    wire bus_wr = psel && penable && pready && pwrite;          // write lands
    wire a_wr   = bus_wr && paddr == `ALCS_OFF_A;               // argument a written
    wire bv_wr  = bus_wr && paddr == `ALCS_OFF_B_VLD && pwdata[0]; // valid set
    // ****************************************
    // properties
    // ****************************************
    access_wait_a: assert property (psel && !penable |=> !pready ##1 pready)
        else $error("no single wait state");
    pready_pulse_a: assert property (pready |=> !pready)
        else $error("pready held");
    slverr_ready_a: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
        else $error("prdata outside answer");
    ctrl_mapped_a: assert property (pready && paddr < 12'h010 |-> !pslverr)
        else $error("control word refused");
    irq_clear_a: assert property ($fell(irq) |-> $past(bus_wr, 2))
        else $error("irq fell without write");
    start_clear_a: assert property ($fell(core_out.start) |-> $past(core_in.ready))
        else $error("start cleared without ready");
    ack_clear_a: assert property ($fell(core_out.b_vld) |-> $past(core_in.b_ack))
        else $error("valid cleared without consume");
    vld_set_a: assert property ($rose(core_out.b_vld) |-> $past(bv_wr))
        else $error("valid set without write");
    arg_hold_a: assert property ($changed(core_out.a_data) |-> $past(a_wr))
        else $error("argument a changed alone");
endmodule

bind alcs_slave alcs_slave_assertions u_assert (
    .sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .core_in(core_in), .core_out(core_out), .irq(irq)
);

/* verification/alcs_core_model.sv */
// behavioural synthesized core: adds a and b, answers c
`timescale 1ns/1ps

module alcs_core_model (
    // clock and reset
    input  wire logic                     sys_clk,
    input  wire logic                     rst_n,
    // slave side
    input  wire alcs_pkg::alcs_core_out_t core_out, // block control, b valid and arguments a and b
    output alcs_pkg::alcs_core_in_t       core_in
);
    logic [2:0] busy_reg; // run countdown, zero when idle
    // ****************************************
    // run control, pulses last one cycle
    // ****************************************
    always_ff @(posedge sys_clk) begin
        core_in.done  <= 1'b0;
        core_in.ready <= 1'b0;
        core_in.b_ack <= 1'b0;
        core_in.c_vld <= 1'b0;
        if (!rst_n) begin
            busy_reg       <= 3'h0;
            core_in.idle   <= 1'b1;
            core_in.c_data <= 32'h0;
        end else if (busy_reg == 3'h0 && core_out.start && core_out.b_vld) begin
            busy_reg       <= 3'h4;
            core_in.idle   <= 1'b0;
            core_in.ready  <= 1'b1;
            core_in.b_ack  <= 1'b1;
            core_in.c_data <= core_out.a_data + core_out.b_data;
        end else if (busy_reg != 3'h0) begin // finishing the run
            busy_reg      <= busy_reg - 3'h1;
            core_in.idle  <= (busy_reg == 3'h1);
            core_in.done  <= (busy_reg == 3'h1);
            core_in.c_vld <= (busy_reg == 3'h1);
        end
    end
endmodule

/* verification/tb.sv */
// register-level bench of the control slave
`timescale 1ns/1ps
`include "alcs_regs.svh"

module tb;
    // ****************************************
    // signals
    // ****************************************
    logic                     sys_clk = 1'b0;
    logic                     rst_n = 1'b0;
    logic                     psel = 1'b0;
    logic                     penable = 1'b0;
    logic                     pwrite = 1'b0;
    logic [11:0]              paddr = 12'h000;
    logic [31:0]              pwdata = 32'h0;
    logic [31:0]              prdata, rd_val, core_mem_rdata;
    logic                     pready, pslverr, irq, err_val;
    logic [3:0]               core_mem_addr = 4'h0;
    alcs_pkg::alcs_core_in_t  core_in;
    alcs_pkg::alcs_core_out_t core_out;
    int                       n_mismatch = 0, num_checks = 0, cyc = 0;

    always #5 sys_clk = ~sys_clk;

    alcs_slave dut (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .core_in(core_in), .core_out(core_out), .core_mem_addr(core_mem_addr),
        .core_mem_rdata(core_mem_rdata), .irq(irq));
    alcs_core_model core (.sys_clk(sys_clk), .rst_n(rst_n), .core_out(core_out), .core_in(core_in));
    // ****************************************
    // tasks
    // ****************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one apb transfer, held until pready
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        @(posedge sys_clk);
        while (pready !== 1'b1) @(posedge sys_clk);
        rd_val = prdata;
        err_val = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        chk(rd_val, exp);
    endtask
    // bounded wait for the core's completion
    task automatic wait_done;
        int i;
        for (i = 0; i < 50 && core_in.done !== 1'b1; i++) @(posedge sys_clk);
        if (core_in.done !== 1'b1) n_mismatch++;
        repeat (3) @(posedge sys_clk);
    endtask
    task automatic stop_test;
        $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // hang guard
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_mismatch++;
            stop_test;
        end
    end
    // ****************************************
    // sequence
    // ****************************************
    initial begin
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        rd(`ALCS_OFF_CTRL, 32'h4);
        rd(`ALCS_OFF_A, `ALCS_ARG_RESET);
        rd(`ALCS_OFF_ISR, 32'h0);
        chk(err_val, 1'b0);
        rd(12'h100, 32'h0);
        chk(err_val, 1'b1);
        wr(12'h100, 32'hFFFF_FFFF);
        chk(err_val, 1'b1);
        wr(`ALCS_OFF_GIE, 32'h1);
        wr(`ALCS_OFF_IER, 32'h3);
        wr(`ALCS_OFF_A, 32'h7);
        wr(`ALCS_OFF_B_DATA, 32'h5);
        rd(`ALCS_OFF_A, 32'h7);
        chk(core_out.b_data, 32'h5);
        wr(`ALCS_OFF_CTRL, 32'h1);
        repeat (10) @(posedge sys_clk);
        rd(`ALCS_OFF_CTRL, 32'h5);
        wr(`ALCS_OFF_B_VLD, 32'h1);
        wait_done;
        rd(`ALCS_OFF_B_VLD, 32'h0);
        rd(`ALCS_OFF_B_ACK, 32'h1);
        rd(`ALCS_OFF_B_ACK, 32'h0);
        rd(`ALCS_OFF_C_DATA, 32'hC);
        rd(`ALCS_OFF_C_VLD, 32'h1);
        rd(`ALCS_OFF_ISR, 32'h3);
        chk(irq, 1'b1);
        rd(`ALCS_OFF_CTRL, 32'h6);
        wr(`ALCS_OFF_ISR, 32'h3);
        repeat (2) @(posedge sys_clk);
        chk(irq, 1'b0);
        // auto restart keeps start across completion
        wr(`ALCS_OFF_CTRL, 32'h81);
        wr(`ALCS_OFF_B_VLD, 32'h1);
        wait_done;
        rd(`ALCS_OFF_CTRL, 32'h87);
        wr(`ALCS_OFF_CTRL, 32'h0);
        wr(`ALCS_OFF_B_DATA, 32'h1);
        wr(`ALCS_OFF_B_VLD, 32'h1);
        wait_done;
        rd(`ALCS_OFF_C_DATA, 32'h8);
        rd(`ALCS_OFF_CTRL, 32'h6);
        // packed array words
        for (int k = 0; k < `ALCS_MEM_WORDS; k++)
            wr(`ALCS_OFF_MEM_BASE + 12'(4 * k), 32'h4433_2200 + 32'(k));
        rd(`ALCS_OFF_MEM_BASE + 12'h03C, 32'h4433_220F);
        core_mem_addr <= 4'h3;
        repeat (3) @(posedge sys_clk);
        chk(core_mem_rdata, 32'h4433_2203);
        stop_test;
    end
endmodule
